// file: rtl/ocmp_pkg.sv
// Purpose: Shared constants and types for the compare channel
// Assumes: 16-bit timers, 3-bit compare mode field
// Notes:   Offsets are bit positions inside the control word
package ocmp_pkg;

    localparam int unsigned CNT_W          = 16;
    localparam int unsigned MODE_POS       = 0;
    localparam int unsigned TSEL_POS       = 3;
    localparam int unsigned FLT_POS        = 4;
    localparam logic [15:0] CTRL_RESET     = 16'h0000;
    localparam logic [15:0] CMP_RESET      = 16'h0000;
    localparam logic [15:0] DUTY_ZERO      = 16'h0000;
    localparam int unsigned OSC_PER_COUNT  = 4;
    localparam int unsigned PIN_SYNC_STAGES = 3;

    // Compare mode field encodings
    typedef enum logic [2:0] {
        MODE_OFF    = 3'b000,
        MODE_LOW    = 3'b001,
        MODE_HIGH   = 3'b010,
        MODE_TOGGLE = 3'b011,
        MODE_SINGLE = 3'b100,
        MODE_CONT   = 3'b101,
        MODE_PWM    = 3'b110,
        MODE_PWMFLT = 3'b111
    } cmp_mode_e;

    // One timer time base as seen by the channel
    typedef struct packed {
        logic [15:0] count;   // timer_count
        logic [15:0] period;  // period_register
        logic        inc;     // One-cycle increment strobe
    } timebase_s;

endpackage : ocmp_pkg

// file: rtl/output_compare_pwm_channel.sv
// Purpose: One output compare / PWM channel driving one pin
// Assumes: Timers live outside; each gives count, period and inc strobe
// Notes:   Pin enable is active low; high impedance when enable is high
`timescale 1ns/1ps
module output_compare_pwm_channel
    import ocmp_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire timebase_s   timer_a,
    input  wire timebase_s   timer_b,
    input  wire logic [15:0] ctrl_wdata,
    input  wire logic        ctrl_we,
    input  wire logic [15:0] main_wdata,
    input  wire logic        main_we,
    input  wire logic [15:0] sec_wdata,
    input  wire logic        sec_we,
    input  wire logic        irq_clear,
    input  wire logic        fault_input_pin_n,
    output logic [15:0]      compare_control_reg,
    output logic [15:0]      compare_main_reg,
    output logic [15:0]      compare_secondary_reg,
    output logic             compare_irq_flag,
    output logic             timer_a_irq_set,
    output logic             timer_b_irq_set,
    output logic             compare_output_pin,
    output logic             compare_output_oe_n
);

    ////////////////////////////////////////////////////////////////////
    // Control state
    ////////////////////////////////////////////////////////////////////
    cmp_mode_e   mode_q;
    logic        timer_select_q;
    logic        fault_flag_q;
    logic [15:0] main_q;
    logic [15:0] sec_q;
    logic        pin_q;
    logic        pulse_done_q;
    logic        irq_q;
    logic        ta_irq_q;
    logic        tb_irq_q;
    logic        fault_lvl;

    pin_sync #(
        .RESET_VAL (1'b1)
    ) u_fault_sync (
        .clk       (clk),
        .nrst      (nrst),
        .pin_in    (fault_input_pin_n),
        .level_out (fault_lvl)
    );

    ////////////////////////////////////////////////////////////////////
    // Time base selection
    ////////////////////////////////////////////////////////////////////
    timebase_s tb;
    logic      is_pwm;
    logic      match_main;
    logic      match_sec;
    logic      rollover;
    logic      step;

    // Select bit cleared picks timer A
    assign tb = timer_select_q ? timer_b : timer_a;
    assign is_pwm = (mode_q == MODE_PWM) || (mode_q == MODE_PWMFLT);
    assign step = tb.inc;
    assign match_main = step && (tb.count == main_q);
    assign match_sec  = step && (tb.count == sec_q);
    // Count at period: next increment clears the timer
    assign rollover = step && (tb.count == tb.period);

    ////////////////////////////////////////////////////////////////////
    // Control word writes and fault flag
    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (!nrst) begin
            mode_q         <= MODE_OFF;
            timer_select_q <= CTRL_RESET[TSEL_POS];
        end else if (ctrl_we) begin
            mode_q         <= cmp_mode_e'(ctrl_wdata[MODE_POS +: 3]);
            timer_select_q <= ctrl_wdata[TSEL_POS];
        end
    end

    // Fault set wins; clears only once pin is high and mode rewritten
    always_ff @(posedge clk) begin
        if (!nrst) begin
            fault_flag_q <= 1'b0;
        end else if (mode_q == MODE_PWMFLT && !fault_lvl) begin
            fault_flag_q <= 1'b1;
        end else if (ctrl_we && fault_lvl) begin
            fault_flag_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Compare registers
    ////////////////////////////////////////////////////////////////////
    // Main is read-only in PWM; rollover latches buffered duty
    always_ff @(posedge clk) begin
        if (!nrst) begin
            main_q <= CMP_RESET;
        end else if (is_pwm && rollover) begin
            main_q <= sec_q;
        end else if (main_we && !is_pwm) begin
            main_q <= main_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            sec_q <= CMP_RESET;
        end else if (sec_we) begin
            sec_q <= sec_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pin state machine per mode
    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pin_q <= 1'b0;
        end else begin
            case (mode_q)
                MODE_OFF: begin
                    pin_q <= 1'b0;
                end
                MODE_LOW: begin
                    // No match on wrap means no change
                    if (match_main) pin_q <= 1'b0;
                end
                MODE_HIGH: begin
                    if (match_main) pin_q <= 1'b1;
                end
                MODE_TOGGLE: begin
                    if (match_main) pin_q <= !pin_q;
                end
                MODE_SINGLE, MODE_CONT: begin
                    if (match_sec && (pin_q || !pulse_done_q)) begin
                        pin_q <= 1'b0;
                    end else if (match_main && !pulse_done_q) begin
                        pin_q <= 1'b1;
                    end
                end
                default: begin
                    // PWM: set at rollover unless the new duty is zero, cleared on duty match
                    if (rollover) begin
                        pin_q <= (main_q != DUTY_ZERO) ||
                                 (sec_q != DUTY_ZERO);
                        if (sec_q == DUTY_ZERO) pin_q <= 1'b0;
                        if (sec_q > tb.period) pin_q <= 1'b1;
                    end else if (match_main && main_q <= tb.period) begin
                        pin_q <= 1'b0;
                    end
                end
            endcase
        end
    end

    // Single-pulse mode fires once until the mode is written again
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pulse_done_q <= 1'b0;
        end else if (ctrl_we) begin
            pulse_done_q <= 1'b0;
        end else if (mode_q == MODE_SINGLE && match_sec && pin_q) begin
            pulse_done_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Event flags
    ////////////////////////////////////////////////////////////////////
    logic cmp_event;
    assign cmp_event = !is_pwm && mode_q != MODE_OFF &&
                       (match_main || (mode_q[2] && match_sec));

    // Sticky compare flag, set wins over clear; never set in PWM
    always_ff @(posedge clk) begin
        if (!nrst) begin
            irq_q <= 1'b0;
        end else if (cmp_event) begin
            irq_q <= 1'b1;
        end else if (irq_clear) begin
            irq_q <= 1'b0;
        end
    end

    // One-cycle set pulses for the selected timer's flag
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ta_irq_q <= 1'b0;
            tb_irq_q <= 1'b0;
        end else begin
            ta_irq_q <= is_pwm && rollover && !timer_select_q;
            tb_irq_q <= is_pwm && rollover && timer_select_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs
    ////////////////////////////////////////////////////////////////////
    always_comb begin
        compare_control_reg = CTRL_RESET;
        compare_control_reg[MODE_POS +: 3] = mode_q;
        compare_control_reg[TSEL_POS] = timer_select_q;
        compare_control_reg[FLT_POS] = fault_flag_q;
    end

    assign compare_main_reg      = main_q;
    assign compare_secondary_reg = sec_q;
    assign compare_irq_flag      = irq_q;
    assign timer_a_irq_set       = ta_irq_q;
    assign timer_b_irq_set       = tb_irq_q;
    assign compare_output_pin    = pin_q;
    // Tri-state while faulted in mode 111
    assign compare_output_oe_n   = (mode_q == MODE_OFF) ||
                                   (fault_flag_q && mode_q == MODE_PWMFLT);

    ////////////////////////////////////////////////////////////////////
    // Checks
    ////////////////////////////////////////////////////////////////////
    sequence s_high_match;
        mode_q == MODE_HIGH && match_main && !ctrl_we;
    endsequence

    AST_HIGH_MATCH: assert property (@(posedge clk) disable iff (!nrst)
        s_high_match |=> pin_q) else $error("high match missed");

    AST_LOW_MATCH: assert property (@(posedge clk) disable iff (!nrst)
        mode_q == MODE_LOW && match_main && !ctrl_we |=> !pin_q)
        else $error("low match missed");

    AST_NO_MATCH_HOLD: assert property (@(posedge clk) disable iff (!nrst)
        mode_q == MODE_TOGGLE && !match_main && !ctrl_we
        |=> $stable(pin_q)) else $error("pin moved w/o match");

    AST_DUTY_LATCH: assert property (@(posedge clk) disable iff (!nrst)
        is_pwm && rollover |=> main_q == $past(sec_q))
        else $error("duty not latched");

    AST_PWM_NO_IRQ: assert property (@(posedge clk) disable iff (!nrst)
        is_pwm && !irq_q |=> !irq_q) else $error("irq in pwm");

    AST_TIMER_IRQ: assert property (@(posedge clk) disable iff (!nrst)
        is_pwm && rollover |=> (ta_irq_q || tb_irq_q))
        else $error("timer flag missed");

    AST_FAULT_TRI: assert property (@(posedge clk) disable iff (!nrst)
        mode_q == MODE_PWMFLT && !fault_lvl && !ctrl_we
        |=> ##0 compare_output_oe_n) else $error("fault no hiz");

    AST_IRQ_STICKY: assert property (@(posedge clk) disable iff (!nrst)
        cmp_event |=> irq_q) else $error("compare flag missed");

    AST_ZERO_DUTY: assert property (@(posedge clk) disable iff (!nrst)
        is_pwm && rollover && sec_q == DUTY_ZERO |=> !pin_q)
        else $error("zero duty drove high");

endmodule : output_compare_pwm_channel

// file: rtl/pin_sync.sv
// Purpose: Three-stage synchroniser for an asynchronous pin
// Assumes: Single clock clk, synchronous active-low reset
// Notes:   Output changes once stages two and three agree
`timescale 1ns/1ps
module pin_sync
    import ocmp_pkg::*;
#(
    parameter logic RESET_VAL = 1'b1
) (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic pin_in,
    output logic      level_out
);

    logic [PIN_SYNC_STAGES-1:0] sync_q;
    logic                       level_q;

    // Shift chain; stage zero feeds stage one only
    always_ff @(posedge clk) begin
        if (!nrst) begin
            sync_q <= {PIN_SYNC_STAGES{RESET_VAL}};
        end else begin
            sync_q <= {sync_q[PIN_SYNC_STAGES-2:0], pin_in};
        end
    end

    // Accept a change only when the last two stages agree
    always_ff @(posedge clk) begin
        if (!nrst) begin
            level_q <= RESET_VAL;
        end else if (sync_q[1] == sync_q[2]) begin
            level_q <= sync_q[2];
        end
    end

    assign level_out = level_q;

endmodule : pin_sync

// file: tb/output_compare_pwm_channel_tb.sv
// Purpose: Self-checking bench for the compare / PWM channel
// Assumes: Timers advance once per clock while running
// Notes:   Both timers are modelled here and driven at the falling edge
`timescale 1ns/1ps
module output_compare_pwm_channel_tb;
    import ocmp_pkg::*;
    logic        clk, nrst, run, ctrl_we, main_we, sec_we, irq_clear, flt_n;
    logic [15:0] ctrl_wdata, main_wdata, sec_wdata, ctrl, mreg, sreg;
    logic        irq, a_set, b_set, pin, oe_n, level;
    timebase_s   tmr_a, tmr_b;
    int          n_mismatch, comparisons, hi, pulses;

    ////////////////////////////////////////////////////////////////////////
    output_compare_pwm_channel dut_u (
        .clk(clk), .nrst(nrst), .timer_a(tmr_a), .timer_b(tmr_b),
        .ctrl_wdata(ctrl_wdata), .ctrl_we(ctrl_we),
        .main_wdata(main_wdata), .main_we(main_we),
        .sec_wdata(sec_wdata), .sec_we(sec_we), .irq_clear(irq_clear),
        .fault_input_pin_n(flt_n), .compare_control_reg(ctrl),
        .compare_main_reg(mreg), .compare_secondary_reg(sreg),
        .compare_irq_flag(irq), .timer_a_irq_set(a_set),
        .timer_b_irq_set(b_set), .compare_output_pin(pin),
        .compare_output_oe_n(oe_n));
    pin_load load_u (.pin(pin), .oe_n(oe_n), .level(level));

    // Clock at 100 ns period
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Timer models: wrap to zero after reaching the period
    always @(negedge clk) begin
        tmr_a.inc <= run;
        tmr_b.inc <= run;
        if (run) begin
            tmr_a.count <= (tmr_a.count == tmr_a.period) ? 16'h0000
                                                          : tmr_a.count + 1;
            tmr_b.count <= (tmr_b.count == tmr_b.period) ? 16'h0000
                                                          : tmr_b.count + 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: value %h expected %h", $time, got, exp);
        end
    endtask : chk_val

    task automatic chk_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: bit %b expected %b", $time, got, exp);
        end
    endtask : chk_bit

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc

    // One-cycle write strobe on the chosen register
    task automatic wr(input int sel, input logic [15:0] d);
        ctrl_wdata = d;
        main_wdata = d;
        sec_wdata  = d;
        ctrl_we    = (sel == 0);
        main_we    = (sel == 1);
        sec_we     = (sel == 2);
        cyc(1);
        {ctrl_we, main_we, sec_we} = 3'b000;
        // Gap cycle so a following write never re-raises a strobe at once
        cyc(1);
    endtask : wr

    task automatic do_reset(input logic [15:0] pa, input logic [15:0] pb);
        run = 1'b0;
        // Let the timer models see the stop before they are reloaded
        cyc(1);
        nrst = 1'b0;
        tmr_a = '{16'h0000, pa, 1'b0};
        tmr_b = '{16'h0000, pb, 1'b0};
        cyc(8);
        nrst = 1'b1;
    endtask : do_reset

    // Count high pin cycles and timer A flag pulses over n cycles
    task automatic meas(input int n);
        hi = 0;
        pulses = 0;
        repeat (n) begin
            @(negedge clk);
            hi += (pin === 1'b1);
            pulses += (a_set === 1'b1);
        end
    endtask : meas

    ////////////////////////////////////////////////////////////////////////
    task automatic t_simple;
        do_reset(16'h0014, 16'h001E);
        chk_val(ctrl, 16'h0000);
        chk_bit(oe_n, 1'b1);
        wr(1, 16'h0019);
        wr(0, 16'h0002);
        run = 1'b1;
        cyc(29);
        chk_bit(pin, 1'b0);
        chk_bit(irq, 1'b0);
        wr(0, 16'h000A);
        cyc(30);
        chk_bit(pin, 1'b1);
        chk_bit(irq, 1'b1);
        irq_clear = 1'b1;
        cyc(1);
        irq_clear = 1'b0;
        cyc(1);
        chk_bit(irq, 1'b0);
        wr(0, 16'h0009);
        cyc(28);
        chk_bit(pin, 1'b0);
        wr(0, 16'h000B);
        cyc(30);
        chk_bit(pin, 1'b1);
        cyc(31);
        chk_bit(pin, 1'b0);
        $display("Test simple modes done");
    endtask : t_simple

    task automatic t_dual;
        do_reset(16'h0014, 16'h0014);
        wr(1, 16'h0004);
        wr(2, 16'h000A);
        wr(0, 16'h0004);
        run = 1'b1;
        meas(63);
        chk_val(16'(hi), 16'h0006);
        chk_bit(irq, 1'b1);
        wr(0, 16'h0004);
        meas(63);
        chk_val(16'(hi), 16'h0006);
        wr(0, 16'h0005);
        meas(63);
        chk_val(16'(hi), 16'h0012);
        $display("Test dual compare done");
    endtask : t_dual

    task automatic t_pwm(input logic [15:0] duty, input logic [15:0] exp);
        do_reset(16'h0014, 16'h0014);
        wr(2, duty);
        wr(0, 16'h0006);
        wr(1, 16'h0003);
        run = 1'b1;
        cyc(25);
        chk_val(mreg, duty);
        meas(63);
        chk_val(16'(hi), exp);
        chk_val(16'(pulses), 16'h0003);
        chk_bit(b_set, 1'b0);
        chk_bit(irq, 1'b0);
        $display("Test pwm duty %h done", duty);
    endtask : t_pwm

    task automatic t_fault;
        do_reset(16'h0014, 16'h0014);
        wr(2, 16'h0008);
        wr(0, 16'h0007);
        run = 1'b1;
        cyc(25);
        chk_bit(oe_n, 1'b0);
        flt_n = 1'b0;
        cyc(8);
        chk_bit(oe_n, 1'b1);
        chk_bit(level, 1'b0);
        chk_bit(ctrl[4], 1'b1);
        flt_n = 1'b1;
        cyc(8);
        chk_bit(oe_n, 1'b1);
        wr(0, 16'h0007);
        cyc(3);
        chk_bit(oe_n, 1'b0);
        chk_bit(ctrl[4], 1'b0);
        $display("Test fault done");
    endtask : t_fault

    task automatic report_and_stop;
        $display("Comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop

    ////////////////////////////////////////////////////////////////////////
    initial begin
        n_mismatch = 0;
        comparisons = 0;
        {ctrl_we, main_we, sec_we, irq_clear} = 4'h0;
        {ctrl_wdata, main_wdata, sec_wdata} = '0;
        flt_n = 1'b1;
        do_reset(16'h0014, 16'h0014);
        t_simple();
        t_dual();
        t_pwm(16'h0008, 16'h001B);
        t_pwm(16'h0000, 16'h0000);
        t_pwm(16'h0019, 16'h003F);
        t_fault();
        report_and_stop();
    end
endmodule : output_compare_pwm_channel_tb

// file: tb/pin_load.sv
// Purpose: External load on the compare output pin
// Assumes: Weak pull-down on the board side of the pin
// Notes:   A released pin settles low instead of holding its last value
`timescale 1ns/1ps
module pin_load (
    input  wire logic pin,
    input  wire logic oe_n,
    output logic      level
);
    // Released pin falls to the pull-down level
    assign level = oe_n ? 1'b0 : pin;
endmodule : pin_load
